// ### core/tcd_regs.vh
// constants shared by the two-channel cycle-steal transfer engine
//
// What this block does
// - two channels steal single bus cycles
// - transfers ignore and never touch interrupts
// - request from software bit or peripheral
// - pin edges, peripherals or software select request
// - enabled channel transfers once per request
// - fast requests may yield fewer transfers
// - forward-to-fixed, fixed-to-forward, fixed-to-fixed addressing
// - never access own control region 20h-3Fh
// - one run covers up to 64K units
// - channel zero first on simultaneous requests
// - unit is byte or word
// - single mode underflow clears enable
// - repeat mode underflow reloads counter
// - underflow raises channel interrupt request
// - reload loads forward pointer and counter
// - fixed pointers writable only while disabled
// - forward register reads working pointer while enabled
// - source reads then destination writes
// - odd word on wide bus doubles cycles
// - byte pin high splits words in two in expansion mode
// - slow areas add one bus clock
// - first transfer after enabling reloads state
// - rewriting enable restarts the channel
// - request bit: hardware set, start or software clear
// - cpu gets one access between channels
`ifndef TCD_REGS_VH
`define TCD_REGS_VH

// register indices inside one channel
`define TCD_IDX_SRC     3'h0
`define TCD_IDX_DST     3'h1
`define TCD_IDX_RELOAD  3'h2
`define TCD_IDX_COUNT   3'h3
`define TCD_IDX_CTRL    3'h4
`define TCD_IDX_SEL     3'h5

// control register field positions
`define TCD_CTRL_EN     0
`define TCD_CTRL_RPT    1
`define TCD_CTRL_U16    2
`define TCD_CTRL_SFWD   3
`define TCD_CTRL_DFWD   4
`define TCD_CTRL_SWREQ  5
`define TCD_CTRL_REQ    6

// reset values
`define TCD_RST_ADDR    20'h00000
`define TCD_RST_CNT     16'h0000
`define TCD_RST_SEL     5'h00

// request source codes; peripheral k is code TCD_SEL_PERIPH + k
`define TCD_SEL_SW      5'h00
`define TCD_SEL_A_FALL  5'h01
`define TCD_SEL_A_BOTH  5'h02
`define TCD_SEL_B_FALL  5'h03
`define TCD_SEL_B_BOTH  5'h04
`define TCD_SEL_PERIPH  5'h05
`define TCD_NPERIPH     20

// address map facts
`define TCD_PROT_LO     20'h00020
`define TCD_PROT_HI     20'h0003F
`define TCD_SFR_HI      20'h003FF

// extra bus clocks on slow areas
`define TCD_SLOW_WAIT   1'b1

`endif

// ### core/tcd_req.v
// request source selection and pin edge detection for one channel
`timescale 1ns/1ps
module tcd_req (
	input  wire        clock,      // bus clock
	input  wire        srst,       // synchronous reset
	input  wire        pin_a,      // synchronised pin a
	input  wire        pin_b,      // synchronised pin b
	input  wire [19:0] periph,     // peripheral request pulses
	input  wire [4:0]  sel,        // selected source
	output reg         trig        // one-cycle request event
);
`include "tcd_regs.vh"

	reg        last_a;             // pin a one clock ago
	reg        last_b;             // pin b one clock ago
	reg  [4:0] pidx;               // peripheral index
	wire       fall_a = last_a & ~pin_a;
	wire       fall_b = last_b & ~pin_b;
	wire       both_a = last_a ^ pin_a;
	wire       both_b = last_b ^ pin_b;

	// edge history
	always @(posedge clock) begin
		if (srst) begin
			last_a <= 1'b1;
			last_b <= 1'b1;
		end else begin
			last_a <= pin_a;
			last_b <= pin_b;
		end
	end

	always @* begin
		pidx = sel - `TCD_SEL_PERIPH;
		trig = 1'b0;
		case (sel)
			`TCD_SEL_SW:     trig = 1'b0;   // only the software bit
			`TCD_SEL_A_FALL: trig = fall_a;
			`TCD_SEL_A_BOTH: trig = both_a;
			`TCD_SEL_B_FALL: trig = fall_b;
			`TCD_SEL_B_BOTH: trig = both_b;
			default: begin
				// out-of-range codes never fire
				if (pidx < `TCD_NPERIPH)
					trig = periph[pidx];
			end
		endcase
	end
endmodule // tcd_req

// ### core/tcd_chan.v
// one transfer channel: pointers, counter, enable and request flag
`timescale 1ns/1ps
module tcd_chan (
	input  wire        clock,      // bus clock
	input  wire        srst,       // synchronous reset
	input  wire        wr,         // register write strobe
	input  wire [2:0]  idx,        // register index
	input  wire [19:0] wdata,      // write data
	input  wire        trig,       // selected request event
	input  wire        start,      // transfer begins now
	input  wire        done,       // transfer finished now
	input  wire [2:0]  rd_idx,     // readback index
	output wire        pend,       // enabled with request
	output wire [19:0] src_addr,   // source of next transfer
	output wire [19:0] dst_addr,   // destination of next transfer
	output wire        unit16,     // word unit
	output wire        enable,     // channel active
	output wire        req_flag,   // pending request
	output wire [4:0]  sel,        // request source select
	output reg         irq,        // underflow pulse
	output reg  [19:0] rd_val      // readback value
);
`include "tcd_regs.vh"

	reg  [19:0] src;               // source pointer
	reg  [19:0] dst;               // destination pointer
	reg  [15:0] rld;               // counter reload
	reg  [15:0] cnt;               // transfer counter
	reg  [19:0] wptr;              // working forward pointer
	reg  [6:0]  ctrl;              // control bits
	reg  [4:0]  srcsel;            // request source
	reg         req;               // pending request
	reg         fresh;             // reload due on next start
	wire        en    = ctrl[`TCD_CTRL_EN];
	wire        sfwd  = ctrl[`TCD_CTRL_SFWD];
	wire        dfwd  = ctrl[`TCD_CTRL_DFWD] & ~sfwd;
	wire [19:0] fwd   = sfwd ? src : dst;
	wire [19:0] cur   = fresh ? fwd : wptr;
	wire [19:0] step  = ctrl[`TCD_CTRL_U16] ? 20'h00002 : 20'h00001;
	wire        wctl  = wr & (idx == `TCD_IDX_CTRL);
	wire        swreq = wctl & wdata[`TCD_CTRL_SWREQ];

	// forward side walks, fixed side stays
	assign src_addr = sfwd ? cur : src;
	assign dst_addr = dfwd ? cur : dst;
	assign unit16   = ctrl[`TCD_CTRL_U16];
	assign enable   = en;
	assign req_flag = req;
	assign sel      = srcsel;
	// only an enabled channel asks for the bus
	assign pend     = en & req;

	// registers and transfer bookkeeping
	always @(posedge clock) begin
		if (srst) begin
			src    <= `TCD_RST_ADDR;
			dst    <= `TCD_RST_ADDR;
			rld    <= `TCD_RST_CNT;
			cnt    <= `TCD_RST_CNT;
			wptr   <= `TCD_RST_ADDR;
			ctrl   <= 7'h00;
			srcsel <= `TCD_RST_SEL;
			req    <= 1'b0;
			fresh  <= 1'b0;
			irq    <= 1'b0;
		end else begin
			irq <= 1'b0;
			if (wr && idx == `TCD_IDX_SRC && (sfwd || !en))
				src <= wdata;
			if (wr && idx == `TCD_IDX_DST && (dfwd || !en))
				dst <= wdata;
			if (wr && idx == `TCD_IDX_RELOAD)
				rld <= wdata[15:0];
			if (wr && idx == `TCD_IDX_SEL)
				srcsel <= wdata[4:0];
			// reload on first start after enabling
			if (start && fresh) begin
				wptr  <= fwd;
				cnt   <= rld;
				fresh <= 1'b0;
			end
			if (done) begin
				if (cnt == 16'h0000) begin
					irq <= 1'b1;
					if (ctrl[`TCD_CTRL_RPT]) begin
						cnt  <= rld;
						wptr <= fwd;
					end else begin
						ctrl[`TCD_CTRL_EN] <= 1'b0;
					end
				end else begin
					cnt  <= cnt - 16'h0001;
					wptr <= wptr + step;
				end
			end
			// software write wins over the underflow stop
			if (wctl) begin
				ctrl[4:0] <= wdata[4:0];
				// writing one restarts from initial state
				if (wdata[`TCD_CTRL_EN])
					fresh <= 1'b1;
			end
			// clear by start or software, set wins
			if (start || (wctl && !wdata[`TCD_CTRL_REQ]))
				req <= 1'b0;
			if (trig || swreq)
				req <= 1'b1;
		end
	end

	// readback, forward register shows working pointer
	always @* begin
		rd_val = 20'h00000;
		case (rd_idx)
			`TCD_IDX_SRC:    rd_val = (en && sfwd) ? cur : src;
			`TCD_IDX_DST:    rd_val = (en && dfwd) ? cur : dst;
			`TCD_IDX_RELOAD: rd_val = {4'h0, rld};
			`TCD_IDX_COUNT:  rd_val = {4'h0, cnt};
			`TCD_IDX_CTRL:   rd_val = {13'h0000, req, 1'b0, ctrl[4:0]};
			`TCD_IDX_SEL:    rd_val = {15'h0000, srcsel};
			default:         rd_val = 20'h00000;
		endcase
	end
endmodule // tcd_chan

// ### core/tcd_top.v
// two-channel cycle-steal transfer engine: arbiter and bus sequencer
`timescale 1ns/1ps
module tcd_top (
	input  wire        clock,          // 25 MHz bus clock
	input  wire        srst,           // synchronous reset
	input  wire        ext_irq_pin_a,  // external request pin a
	input  wire        ext_irq_pin_b,  // external request pin b
	input  wire        byte_pin,       // external bus width pin
	input  wire        exp_mode,       // expansion or processor mode
	input  wire        sw_wait,        // software wait enabled
	input  wire [19:0] periph_irq,     // peripheral request pulses
	input  wire        reg_wr,         // register write strobe
	input  wire        reg_ch,         // channel of register access
	input  wire [2:0]  reg_idx,        // register index of write
	input  wire [19:0] reg_wdata,      // register write data
	input  wire [2:0]  rd_idx,         // register index of read
	input  wire        rd_ch,          // channel of read
	input  wire [15:0] mem_rdata,      // bus read data
	output reg  [19:0] rd_data,        // register read data
	output reg         bus_own,        // engine holds the bus
	output reg  [19:0] mem_addr,       // bus address
	output reg         mem_rd,         // bus read strobe
	output reg         mem_wr,         // bus write strobe
	output reg         mem_word,       // 16-bit access
	output reg  [15:0] mem_wdata,      // bus write data
	output reg  [1:0]  dma_irq,        // underflow pulses
	output reg  [1:0]  ch_active,      // enable bits
	output reg  [1:0]  ch_req          // request bits
);
`include "tcd_regs.vh"

	// sequencer states, one-hot
	localparam ST_IDLE = 4'b0001;     // waiting for a request
	localparam ST_RD   = 4'b0010;     // source read cycles
	localparam ST_WR   = 4'b0100;     // destination write cycles
	localparam ST_GAP  = 4'b1000;     // one access for the cpu

	reg  [3:0]  state;                // sequencer state
	reg         cur;                  // channel being served
	reg  [19:0] sa;                   // latched source
	reg  [19:0] da;                   // latched destination
	reg         u16;                  // latched unit size
	reg         beat;                 // second half of a split unit
	reg         wt;                   // wait clock taken
	reg  [15:0] dbuf;                 // data in flight
	reg  [1:0]  start;                // start pulses to channels
	reg  [1:0]  done;                 // done pulses to channels

	// two-flop synchronisers for pins
	reg         a_s1;                 // pin a first stage
	reg         a_s2;                 // pin a second stage
	reg         b_s1;                 // pin b first stage
	reg         b_s2;                 // pin b second stage
	reg         w_s1;                 // width pin first stage
	reg         w_s2;                 // width pin second stage

	wire [1:0]  pend;                 // channel wants the bus
	wire [19:0] sad0;                 // channel zero source
	wire [19:0] sad1;                 // channel one source
	wire [19:0] dad0;                 // channel zero destination
	wire [19:0] dad1;                 // channel one destination
	wire [1:0]  uw;                   // word units per channel
	wire [1:0]  en;                   // enable bits
	wire [1:0]  rq;                   // request bits
	wire [4:0]  sel0;                 // source select zero
	wire [4:0]  sel1;                 // source select one
	wire [1:0]  trig;                 // selected request events
	wire [1:0]  irq;                  // underflow pulses
	wire [19:0] rv0;                  // readback zero
	wire [19:0] rv1;                  // readback one

	// narrow bus only outside single-chip mode
	wire        narrow = w_s2 & exp_mode;

	// own control region is never touched
	function prot;
		input [19:0] a;
		begin
			prot = (a >= `TCD_PROT_LO) && (a <= `TCD_PROT_HI);
		end
	endfunction

	// special function area, or any address while software wait is on, is slow
	function slow;
		input [19:0] a;
		begin
			slow = (a <= `TCD_SFR_HI) | sw_wait;
		end
	endfunction

	// word splits on odd address or narrow bus
	function split;
		input [19:0] a;
		input        w;
		begin
			split = w & (a[0] | narrow);
		end
	endfunction

	// pin synchronisers; only stage two feeds logic
	always @(posedge clock) begin
		if (srst) begin
			a_s1 <= 1'b1;
			a_s2 <= 1'b1;
			b_s1 <= 1'b1;
			b_s2 <= 1'b1;
			w_s1 <= 1'b0;
			w_s2 <= 1'b0;
		end else begin
			a_s1 <= ext_irq_pin_a;
			a_s2 <= a_s1;
			b_s1 <= ext_irq_pin_b;
			b_s2 <= b_s1;
			w_s1 <= byte_pin;
			w_s2 <= w_s1;
		end
	end

	tcd_req u_req0 (
		.clock  (clock),
		.srst   (srst),
		.pin_a  (a_s2),
		.pin_b  (b_s2),
		.periph (periph_irq),
		.sel    (sel0),
		.trig   (trig[0])
	);

	tcd_req u_req1 (
		.clock  (clock),
		.srst   (srst),
		.pin_a  (a_s2),
		.pin_b  (b_s2),
		.periph (periph_irq),
		.sel    (sel1),
		.trig   (trig[1])
	);

	// channel_zero registers
	tcd_chan u_channel_zero (
		.clock    (clock),
		.srst     (srst),
		.wr       (reg_wr & ~reg_ch),
		.idx      (reg_idx),
		.wdata    (reg_wdata),
		.trig     (trig[0]),
		.start    (start[0]),
		.done     (done[0]),
		.rd_idx   (rd_idx),
		.pend     (pend[0]),
		.src_addr (sad0),
		.dst_addr (dad0),
		.unit16   (uw[0]),
		.enable   (en[0]),
		.req_flag (rq[0]),
		.sel      (sel0),
		.irq      (irq[0]),
		.rd_val   (rv0)
	);

	// channel_one registers
	tcd_chan u_channel_one (
		.clock    (clock),
		.srst     (srst),
		.wr       (reg_wr & reg_ch),
		.idx      (reg_idx),
		.wdata    (reg_wdata),
		.trig     (trig[1]),
		.start    (start[1]),
		.done     (done[1]),
		.rd_idx   (rd_idx),
		.pend     (pend[1]),
		.src_addr (sad1),
		.dst_addr (dad1),
		.unit16   (uw[1]),
		.enable   (en[1]),
		.req_flag (rq[1]),
		.sel      (sel1),
		.irq      (irq[1]),
		.rd_val   (rv1)
	);

	// status mirrors, registered so outputs come from flops
	always @(posedge clock) begin
		if (srst) begin
			rd_data   <= 20'h00000;
			dma_irq   <= 2'b00;
			ch_active <= 2'b00;
			ch_req    <= 2'b00;
		end else begin
			rd_data   <= rd_ch ? rv1 : rv0;
			dma_irq   <= irq;
			ch_active <= en;
			ch_req    <= rq;
		end
	end

	// start pulses are combinational so the channel sees them at once
	always @* begin
		start = 2'b00;
		if (state == ST_IDLE) begin
			if (pend[0])
				start = 2'b01;
			else if (pend[1])
				start = 2'b10;
		end
	end

	// bus sequencer: steal one unit, read then write
	// no interrupt state is read or written here
	always @(posedge clock) begin
		if (srst) begin
			state     <= ST_IDLE;
			cur       <= 1'b0;
			sa        <= 20'h00000;
			da        <= 20'h00000;
			u16       <= 1'b0;
			beat      <= 1'b0;
			wt        <= 1'b0;
			dbuf      <= 16'h0000;
			done      <= 2'b00;
			bus_own   <= 1'b0;
			mem_addr  <= 20'h00000;
			mem_rd    <= 1'b0;
			mem_wr    <= 1'b0;
			mem_word  <= 1'b0;
			mem_wdata <= 16'h0000;
		end else begin
			done <= 2'b00;
			case (state)
				ST_IDLE: begin
					if (start != 2'b00) begin
						// latch the unit and drive the first read
						cur      <= start[1];
						sa       <= start[1] ? sad1 : sad0;
						da       <= start[1] ? dad1 : dad0;
						u16      <= start[1] ? uw[1] : uw[0];
						beat     <= 1'b0;
						wt       <= 1'b0;
						dbuf     <= 16'h0000;
						bus_own  <= 1'b1;
						mem_addr <= start[1] ? sad1 : sad0;
						mem_rd   <= ~prot(start[1] ? sad1 : sad0);
						mem_word <= ~split(start[1] ? sad1 : sad0,
						                   start[1] ? uw[1] : uw[0])
						            & (start[1] ? uw[1] : uw[0]);
						state    <= ST_RD;
					end
				end
				ST_RD: begin
					// one extra clock on slow areas
					if (slow(mem_addr) && !wt) begin
						wt <= `TCD_SLOW_WAIT;
					end else begin
						wt <= 1'b0;
						// protected reads return zero
						if (!split(sa, u16)) begin
							dbuf <= prot(mem_addr) ? 16'h0000 :
							        (u16 ? mem_rdata : {8'h00, mem_rdata[7:0]});
						end else if (!beat) begin
							dbuf[7:0] <= prot(mem_addr) ? 8'h00 : mem_rdata[7:0];
						end else begin
							dbuf[15:8] <= prot(mem_addr) ? 8'h00 : mem_rdata[7:0];
						end
						if (split(sa, u16) && !beat) begin
							// second byte of a split word read
							beat     <= 1'b1;
							mem_addr <= sa + 20'h00001;
							mem_rd   <= ~prot(sa + 20'h00001);
						end else begin
							// hand over to the destination write
							beat      <= 1'b0;
							mem_rd    <= 1'b0;
							mem_addr  <= da;
							mem_wr    <= ~prot(da);
							mem_word  <= u16 & ~split(da, u16);
							state     <= ST_WR;
							if (!split(sa, u16))
								mem_wdata <= prot(mem_addr) ? 16'h0000 :
								             (u16 ? mem_rdata :
								              {8'h00, mem_rdata[7:0]});
							else
								mem_wdata <= {prot(mem_addr) ? 8'h00 : mem_rdata[7:0],
								              dbuf[7:0]};
						end
					end
				end
				ST_WR: begin
					if (slow(mem_addr) && !wt) begin
						wt <= `TCD_SLOW_WAIT;
					end else begin
						wt <= 1'b0;
						if (split(da, u16) && !beat) begin
							// high byte travels in the low lane
							beat      <= 1'b1;
							mem_addr  <= da + 20'h00001;
							mem_wr    <= ~prot(da + 20'h00001);
							mem_wdata <= {8'h00, mem_wdata[15:8]};
						end else begin
							// unit complete, release the bus
							beat     <= 1'b0;
							mem_wr   <= 1'b0;
							mem_word <= 1'b0;
							bus_own  <= 1'b0;
							done     <= cur ? 2'b10 : 2'b01;
							state    <= ST_GAP;
						end
					end
				end
				ST_GAP: begin
					// cpu gets one access before the next steal
					state <= ST_IDLE;
				end
				default: begin
					state   <= ST_IDLE;
					bus_own <= 1'b0;
					mem_rd  <= 1'b0;
					mem_wr  <= 1'b0;
				end
			endcase
		end
	end
endmodule // tcd_top

// ### tb/tcd_mem_model.sv
// shared memory model on the far side of the engine bus
`timescale 1ns/1ps
module tcd_mem_model (
	input  wire        clock,      // bus clock
	input  wire [19:0] mem_addr,   // bus address
	input  wire        mem_rd,     // read strobe
	input  wire        mem_wr,     // write strobe
	input  wire        mem_word,   // 16-bit access
	input  wire [15:0] mem_wdata,  // write data
	output reg  [15:0] mem_rdata   // read data
);
	reg [7:0]  mem [0:4095];  // byte store on low address bits
	reg [15:0] junk;          // released bus pattern
	integer    j;
	// known content so the bench can predict every byte
	initial begin
		for (j = 0; j < 4096; j = j + 1)
			mem[j] = j[7:0] ^ 8'hA5;
		junk = 16'h5A5A;
	end
	// released bus flips every clock, never holds old data
	always @(posedge clock) begin
		junk <= ~junk;
		if (mem_wr) begin
			mem[mem_addr[11:0]] <= mem_wdata[7:0];
			if (mem_word)
				mem[mem_addr[11:0] + 12'h1] <= mem_wdata[15:8];
		end
	end
	// upper lane is junk on byte reads
	always @* begin
		if (mem_rd)
			mem_rdata = {mem_word ? mem[mem_addr[11:0] + 12'h1] : junk[15:8],
				mem[mem_addr[11:0]]};
		else
			mem_rdata = junk;
	end
endmodule // tcd_mem_model

// ### tb/tcd_top_assertions.sv
// bus side checks of the transfer engine
`timescale 1ns/1ps
module tcd_top_assertions (
	input wire        clock,     // bus clock
	input wire        srst,      // synchronous reset
	input wire        bus_own,   // engine holds the bus
	input wire [19:0] mem_addr,  // bus address
	input wire        mem_rd,    // read strobe
	input wire        mem_wr,    // write strobe
	input wire        mem_word,  // 16-bit access
	input wire [1:0]  dma_irq,   // underflow pulses
	input wire [1:0]  ch_active  // enable bits
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	AST_ONE_STROBE: assert property (!(mem_rd && mem_wr))
		else $error("read and write strobes together");
	AST_STROBE_OWNED: assert property ((mem_rd || mem_wr) |-> bus_own)
		else $error("strobe without bus ownership");
	AST_NO_OWN_REGION: assert property ((mem_rd || mem_wr) |->
		(mem_addr < 20'h00020 || mem_addr > 20'h0003F))
		else $error("access inside own control region");
	AST_READ_FIRST: assert property ($rose(bus_own) |-> !mem_wr)
		else $error("unit opened with a write");
	AST_CPU_SLOT: assert property ($fell(bus_own) |-> !bus_own [*2])
		else $error("no cpu slot after a unit");
	AST_UNIT_BOUNDED: assert property ($rose(bus_own) |-> ##[1:9] !bus_own)
		else $error("unit held the bus too long");
	AST_WORD_EVEN: assert property ((mem_word && (mem_rd || mem_wr)) |-> !mem_addr[0])
		else $error("word access on odd address");
	AST_ACTIVE_ONLY: assert property ($rose(bus_own) |-> ch_active != 2'b00)
		else $error("transfer with no active channel");
	AST_IRQ_QUIET: assert property (dma_irq != 2'b00 |->
		$onehot(dma_irq) && $past(bus_own, 3) && !$past(bus_own, 2))
		else $error("underflow pulse not two clocks after a unit");
endmodule // tcd_top_assertions

bind tcd_top tcd_top_assertions chk_u (.clock(clock), .srst(srst), .bus_own(bus_own),
	.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_word(mem_word),
	.dma_irq(dma_irq), .ch_active(ch_active));

// ### tb/tcd_top_tb.sv
// self-checking bench for the two-channel cycle-steal engine
`timescale 1ns/1ps
module tcd_top_tb;
	reg         clock, srst, pin_a, pin_b, byte_pin, exp_mode, sw_wait;
	reg         reg_wr, reg_ch, rd_ch;
	reg  [2:0]  reg_idx, rd_idx;
	reg  [19:0] periph_irq, reg_wdata, v;
	wire [15:0] mem_rdata, mem_wdata;
	wire [19:0] rd_data, mem_addr;
	wire        bus_own, mem_rd, mem_wr, mem_word;
	wire [1:0]  dma_irq, ch_active, ch_req;
	reg  [36:0] wq [$];  // write log: word, address, data
	reg  [20:0] wlast;   // write strobe and address one clock ago
	reg  [15:0] rnd;     // stimulus lfsr state
	integer     n_mismatch, samples_checked, irq0, irq1, i;

	tcd_top dut_u (.clock(clock), .srst(srst), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
		.byte_pin(byte_pin), .exp_mode(exp_mode), .sw_wait(sw_wait), .periph_irq(periph_irq),
		.reg_wr(reg_wr), .reg_ch(reg_ch), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
		.rd_idx(rd_idx), .rd_ch(rd_ch), .mem_rdata(mem_rdata), .rd_data(rd_data),
		.bus_own(bus_own), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_word(mem_word), .mem_wdata(mem_wdata), .dma_irq(dma_irq),
		.ch_active(ch_active), .ch_req(ch_req));
	tcd_mem_model mem_u (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_word(mem_word), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// log every write strobe and count underflow pulses
	// a strobe stretched by a wait clock is still one bus cycle
	always @(posedge clock) begin
		if (mem_wr === 1'b1 && wlast !== {1'b1, mem_addr})
			wq.push_back({mem_word, mem_addr, mem_wdata});
		wlast <= {mem_wr, mem_addr};
		if (dma_irq[0] === 1'b1)
			irq0 = irq0 + 1;
		if (dma_irq[1] === 1'b1)
			irq1 = irq1 + 1;
	end
	// predicted memory byte
	function [7:0] eb(input [19:0] a);
		eb = a[7:0] ^ 8'hA5;
	endfunction
	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task close_out;
		begin
			if (n_mismatch == 0 && samples_checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [19:0] e, input [19:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// byte writes only carry lane 7:0
	task chk_wr(input integer n, input [19:0] a, input [15:0] d, input w);
		reg [36:0] e;
		begin
			e = (n < wq.size()) ? wq[n] : 37'h0;
			chk("wr_addr", a, e[35:16]);
			chk("wr_word", w, e[36]);
			chk("wr_data", w ? d : {8'h00, d[7:0]}, w ? e[15:0] : {8'h00, e[7:0]});
		end
	endtask
	task wreg(input c, input [2:0] x, input [19:0] d);
		begin
			@(negedge clock);
			reg_wr = 1'b1;
			reg_ch = c;
			reg_idx = x;
			reg_wdata = d;
			@(negedge clock);
			reg_wr = 1'b0;
		end
	endtask
	// readback is registered one clock after select
	task rreg(input c, input [2:0] x);
		begin
			@(negedge clock);
			rd_ch = c;
			rd_idx = x;
			@(negedge clock);
			v = rd_data;
		end
	endtask
	task pulse(input integer k, input [19:0] nz);
		begin
			@(negedge clock);
			periph_irq = (20'h1 << k) | (nz & ~(20'h1 << k));
			@(negedge clock);
			periph_irq = 20'h00000;
		end
	endtask
	// bounded wait for the write log, then gap and idle clocks
	task wait_wr(input integer n);
		integer k;
		begin
			k = 0;
			while (wq.size() < n && k < 300) begin
				@(negedge clock);
				k = k + 1;
			end
			repeat (4) @(negedge clock);
			chk("wr_count", n, wq.size());
		end
	endtask
	// hang guard, far beyond the expected few hundred clocks
	initial begin
		repeat (30000) @(posedge clock);
		n_mismatch = n_mismatch + 1;
		close_out;
	end

	initial begin
		{pin_a, pin_b, byte_pin, exp_mode, sw_wait, reg_wr, reg_ch, rd_ch} = 8'hC0;
		{reg_idx, rd_idx, periph_irq, reg_wdata} = 46'h0;
		{n_mismatch, samples_checked, irq0, irq1} = 0;
		rnd = 16'hC607;
		srst = 1'b1;
		repeat (20) @(posedge clock);
		@(negedge clock);
		srst = 1'b0;
		// peripheral-fed single byte run with a restart
		wreg(1'b0, 3'h5, 20'h00005);
		wreg(1'b0, 3'h0, 20'h01000);
		wreg(1'b0, 3'h1, 20'h01200);
		wreg(1'b0, 3'h2, 20'h00002);
		wreg(1'b0, 3'h4, 20'h00009);
		for (i = 1; i < 6; i = i + 1) begin
			if (i == 3) begin
				rreg(1'b0, 3'h0);
				chk("src_ptr", 20'h01002, v);
				wreg(1'b0, 3'h1, 20'h01234);
				rreg(1'b0, 3'h1);
				chk("dst_fix", 20'h01200, v);
				chk("irq0", 0, irq0);
				wreg(1'b0, 3'h4, 20'h00009);
			end
			pulse(0, 20'h0);
			wait_wr(i);
		end
		for (i = 0; i < 5; i = i + 1)
			chk_wr(i, 20'h01200, eb(20'h01000 + ((i < 2) ? i : i - 2)), 0);
		chk("irq0", 1, irq0);
		chk("act0", 0, ch_active[0]);
		// disabled channel keeps one merged request
		wreg(1'b1, 3'h5, 20'h00006);
		wreg(1'b1, 3'h0, 20'h01001);
		wreg(1'b1, 3'h1, 20'h01301);
		wreg(1'b1, 3'h4, 20'h00000);
		for (i = 0; i < 3; i = i + 1)
			pulse(1, 20'h0);
		repeat (20) @(negedge clock);
		chk("req1", 1, ch_req[1]);
		chk("wr_count", 5, wq.size());
		wreg(1'b1, 3'h4, 20'h0004D);
		wait_wr(7);
		repeat (20) @(negedge clock);
		chk("wr_count", 7, wq.size());
		chk_wr(5, 20'h01301, eb(20'h01001), 0);
		chk_wr(6, 20'h01302, eb(20'h01002), 0);
		// request bit: hardware sets, writing the bit can only clear it
		pulse(0, 20'h0);
		wreg(1'b0, 3'h4, 20'h00040);
		rreg(1'b0, 3'h4);
		chk("ctrl0", 20'h00040, v);
		wreg(1'b0, 3'h4, 20'h00000);
		wreg(1'b0, 3'h4, 20'h00040);
		rreg(1'b0, 3'h4);
		chk("ctrl0", 20'h00000, v);
		// both channels on one pin edge
		wreg(1'b0, 3'h5, 20'h00001);
		wreg(1'b1, 3'h5, 20'h00001);
		wreg(1'b0, 3'h4, 20'h00009);
		wreg(1'b1, 3'h4, 20'h0000D);
		@(negedge clock);
		pin_a = 1'b0;
		wait_wr(10);
		chk_wr(7, 20'h01200, eb(20'h01000), 0);
		chk_wr(8, 20'h01301, eb(20'h01001), 0);
		pin_a = 1'b1;
		// narrow bus splits a word, wide bus moves it whole
		wreg(1'b0, 3'h4, 20'h00000);
		byte_pin = 1'b1;
		exp_mode = 1'b1;
		wreg(1'b0, 3'h0, 20'h01010);
		wreg(1'b0, 3'h1, 20'h01210);
		wreg(1'b0, 3'h2, 20'h00000);
		wreg(1'b0, 3'h4, 20'h0002D);
		wait_wr(12);
		byte_pin = 1'b0;
		wreg(1'b0, 3'h4, 20'h0002D);
		wait_wr(13);
		chk_wr(10, 20'h01210, eb(20'h01010), 0);
		chk_wr(11, 20'h01211, eb(20'h01011), 0);
		chk_wr(12, 20'h01210, {eb(20'h01011), eb(20'h01010)}, 1);
		// own control region reads as zero, slow clocks on
		sw_wait = 1'b1;
		wreg(1'b1, 3'h0, 20'h00020);
		wreg(1'b1, 3'h1, 20'h01600);
		wreg(1'b1, 3'h4, 20'h00029);
		wait_wr(14);
		chk_wr(13, 20'h01600, 16'h0000, 0);
		// every pin and peripheral request source once, fixed to fixed, repeat mode
		wreg(1'b1, 3'h0, 20'h01400);
		wreg(1'b1, 3'h1, 20'h01500);
		for (i = 1; i < 25; i = i + 1) begin
			wreg(1'b1, 3'h5, i[19:0]);
			wreg(1'b1, 3'h4, 20'h00003);
			rnd = lfsr(rnd);
			sw_wait = rnd[0];
			if (i < 5) begin
				@(negedge clock);
				if (i < 3)
					pin_a = ~pin_a;
				else
					pin_b = ~pin_b;
			end else
				pulse(i - 5, {rnd, rnd[3:0]});
			wait_wr(14 + i);
		end
		chk("irq1", 27, irq1);
		chk("act1", 1, ch_active[1]);
		close_out;
	end
endmodule // tcd_top_tb
